//--- design/ee_cfg.svh
`ifndef EE_CFG_SVH
`define EE_CFG_SVH
// address byte: type 1010, select bits 00, then address top bit and direction
`define EE_DEV_TYPE 6'h28
`define EE_LAST_BIT 4'h7
`define EE_ACK_BIT 4'h8
`define EE_BIT_ZERO 4'h0
`define EE_ARRAY_BYTES 512
`define EE_PAGE_BYTES 16
`define EE_ADDR_RESET 9'h000
`define EE_TWC_NS 5000000
`define EE_CLK_NS 10
`endif

//--- design/ee_pkg.sv
package ee_pkg;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_DEVADDR = 6'h02,
      ST_WORDADDR = 6'h04,
      ST_WDATA = 6'h08,
      ST_RDATA = 6'h10,
      ST_IGNORE = 6'h20
   } ee_state_t;
   typedef struct packed {
      logic scl;
      logic sda;
   } ee_line_t;
endpackage : ee_pkg

//--- design/ee_slave_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "ee_cfg.svh"
// What this block does
// - data rising while clock high is a stop, ending any transaction.
// - stop after a read puts the device back into standby.
// - after eight bits, receiver pulls data low on ninth clock to acknowledge.
// - acknowledge address byte only on match; in writes acknowledge following bytes.
// - in reads send byte, sample acknowledge, continue only if acknowledged.
// - byte write: address, word address, data; stop then starts write cycle.
// - during the write cycle ignore the bus, data output released.
// - write to a protected block gets no acknowledge.
// - page write increments only the low address bits, wrapping inside page.
// - more than sixteen bytes overwrite earlier loaded bytes in turn.
// - stop mid-byte or before one acknowledged data byte writes nothing.
// - address byte gets no acknowledge while busy, acknowledged once done.
// - direction bit one selects read; current, random and sequential reads.
// - address counter holds last read address plus one.
// - current read acknowledges then sends byte at counter address.
// - stop after word address loads counter, device goes to standby.
// - sequential read runs through all addresses, wrapping to zero.
// - address byte is type 1010, two zero bits, top address bit, direction.
// - nine address bits: top from address byte, low eight from word byte.
// - with write permit clear writes are ignored, data byte not acknowledged.
// - with upper half lock set addresses 100h to 1FFh are protected.
module ee_slave_core
   import ee_pkg::*;
#(
   parameter int WR_CYCLES = `EE_TWC_NS / `EE_CLK_NS
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic write_permit_latch_i,
   input wire logic upper_half_lock_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic busy_o,
   output logic standby_o
);
   localparam int CW = $clog2(WR_CYCLES + 1);

   function automatic logic dev_match(input logic [7:0] b);
      return b[7:2] == `EE_DEV_TYPE;
   endfunction : dev_match

   function automatic logic locked(input logic lock, input logic [8:0] a);
      return lock & a[8];
   endfunction : locked

   ee_line_t ln_s1_r;
   ee_line_t ln_s2_r;
   ee_line_t ln_d_r;
   ee_state_t state_r;
   logic [3:0] bit_r;
   logic [7:0] rx_r;
   logic [7:0] tx_r;
   logic oe_r;
   logic mack_r;
   logic a8_r;
   logic [8:0] addr_r;
   logic ok_r;
   logic busy_r;
   logic [CW-1:0] wcnt_r;
   logic [4:0] page_r;
   logic [7:0] pbuf_r [`EE_PAGE_BYTES];
   logic [`EE_PAGE_BYTES-1:0] vld_r;
   logic [7:0] mem_r [`EE_ARRAY_BYTES];
   logic seen_r;

   // two stages before any logic, third only for edge finding
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         ln_s1_r <= 2'h3;
         ln_s2_r <= 2'h3;
         ln_d_r <= 2'h3;
      end else begin
         ln_s1_r <= '{scl: scl_i, sda: sda_i};
         ln_s2_r <= ln_s1_r;
         ln_d_r <= ln_s2_r;
      end
   end

   logic rise_e;
   logic fall_e;
   logic start_e;
   logic stop_e;
   logic active;
   logic take_w;
   logic launch_w;
   logic done_w;
   logic rd_load;
   assign rise_e = ln_s2_r.scl & ~ln_d_r.scl;
   assign fall_e = ~ln_s2_r.scl & ln_d_r.scl & seen_r;
   assign start_e = ln_s2_r.scl & ln_d_r.scl & ln_d_r.sda & ~ln_s2_r.sda;
   assign stop_e = ln_s2_r.scl & ln_d_r.scl & ~ln_d_r.sda & ln_s2_r.sda;
   assign active = (state_r != ST_IDLE) && (state_r != ST_IGNORE) && !busy_r
      && !stop_e && !start_e;
   assign take_w = active && fall_e && bit_r == `EE_LAST_BIT && state_r == ST_WDATA
      && write_permit_latch_i && !locked(upper_half_lock_i, addr_r);
   // a stop with the bit counter back at zero means the last byte and its ack finished
   assign launch_w = !busy_r && stop_e && state_r == ST_WDATA
      && bit_r == `EE_BIT_ZERO && ok_r;
   assign done_w = busy_r && wcnt_r == CW'(WR_CYCLES - 1);
   assign rd_load = active && fall_e && bit_r == `EE_ACK_BIT && state_r == ST_RDATA
      && mack_r;

   // the clock fall that closes a start is not a data bit, so it must not count
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         seen_r <= 1'b0;
      end else if (start_e) begin
         seen_r <= 1'b0;
      end else if (rise_e) begin
         seen_r <= 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         state_r <= ST_IDLE;
         bit_r <= `EE_BIT_ZERO;
         rx_r <= 8'h00;
         tx_r <= 8'h00;
         oe_r <= 1'b0;
         mack_r <= 1'b0;
         a8_r <= 1'b0;
         addr_r <= `EE_ADDR_RESET;
         ok_r <= 1'b0;
      end else if (busy_r) begin
         state_r <= ST_IDLE;
         oe_r <= 1'b0;
      end else if (stop_e) begin
         state_r <= ST_IDLE;
         bit_r <= `EE_BIT_ZERO;
         oe_r <= 1'b0;
      end else if (start_e) begin
         state_r <= ST_DEVADDR;
         bit_r <= `EE_BIT_ZERO;
         oe_r <= 1'b0;
         ok_r <= 1'b0;
      end else if (active) begin
         if (rise_e && bit_r != `EE_ACK_BIT) begin
            rx_r <= {rx_r[6:0], ln_s2_r.sda};
         end
         // own ack drive must not be mistaken for the master's
         if (rise_e && bit_r == `EE_ACK_BIT && !oe_r) begin
            mack_r <= ~ln_s2_r.sda;
         end
         if (fall_e) begin
            if (bit_r == `EE_LAST_BIT) begin
               bit_r <= `EE_ACK_BIT;
               unique case (state_r)
                  ST_DEVADDR: begin
                     if (dev_match(rx_r)) begin
                        oe_r <= 1'b1;
                        a8_r <= rx_r[1];
                        mack_r <= 1'b1;
                        state_r <= rx_r[0] ? ST_RDATA : ST_WORDADDR;
                     end else begin
                        state_r <= ST_IGNORE;
                     end
                  end
                  ST_WORDADDR: begin
                     oe_r <= 1'b1;
                     addr_r <= {a8_r, rx_r};
                     state_r <= ST_WDATA;
                  end
                  ST_WDATA: begin
                     if (take_w) begin
                        oe_r <= 1'b1;
                        ok_r <= 1'b1;
                        addr_r[3:0] <= addr_r[3:0] + 4'h1;
                     end else begin
                        state_r <= ST_IGNORE;
                        ok_r <= 1'b0;
                     end
                  end
                  ST_RDATA, ST_IDLE, ST_IGNORE: begin
                     oe_r <= 1'b0;
                  end
               endcase
            end else if (bit_r == `EE_ACK_BIT) begin
               bit_r <= `EE_BIT_ZERO;
               if (state_r == ST_RDATA) begin
                  if (mack_r) begin
                     tx_r <= mem_r[addr_r];
                     oe_r <= ~mem_r[addr_r][7];
                     addr_r <= addr_r + 9'h001;
                  end else begin
                     state_r <= ST_IGNORE;
                     oe_r <= 1'b0;
                  end
               end else begin
                  oe_r <= 1'b0;
               end
            end else begin
               bit_r <= bit_r + 4'h1;
               if (state_r == ST_RDATA) begin
                  tx_r <= {tx_r[6:0], 1'b0};
                  oe_r <= ~tx_r[6];
               end
            end
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         busy_r <= 1'b0;
         wcnt_r <= '0;
      end else if (launch_w) begin
         busy_r <= 1'b1;
         wcnt_r <= '0;
      end else if (done_w) begin
         busy_r <= 1'b0;
      end else if (busy_r) begin
         wcnt_r <= wcnt_r + CW'(1);
      end
   end

   // bytes gather in a page buffer so an aborted load leaves the array untouched
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         vld_r <= '0;
         page_r <= 5'h00;
      end else if (active && fall_e && bit_r == `EE_LAST_BIT && state_r == ST_WORDADDR) begin
         vld_r <= '0;
      end else if (take_w) begin
         vld_r[addr_r[3:0]] <= 1'b1;
         page_r <= addr_r[8:4];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (take_w) begin
         pbuf_r[addr_r[3:0]] <= rx_r;
      end
   end

   // nonvolatile contents carry no reset
   always_ff @(posedge mclk_i) begin
      if (done_w) begin
         for (int i = 0; i < `EE_PAGE_BYTES; i++) begin
            if (vld_r[i]) begin
               mem_r[{page_r, 4'(i)}] <= pbuf_r[i];
            end
         end
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = oe_r;
   assign busy_o = busy_r;
   assign standby_o = (state_r == ST_IDLE) && !busy_r;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   stop_ends_a: assert property (stop_e |=> state_r == ST_IDLE)
      else $error("stop did not end transaction");
   read_standby_a: assert property (stop_e && state_r == ST_RDATA && !busy_r
      |=> standby_o)
      else $error("no standby after read stop");
   busy_quiet_a: assert property (busy_r |-> !sda_oe_o && state_r == ST_IDLE)
      else $error("bus driven during write cycle");
   busy_noack_a: assert property (busy_r && start_e |=> ##[1:40] !sda_oe_o)
      else $error("ack while busy");
   word_ack_a: assert property (active && fall_e && bit_r == `EE_LAST_BIT
      && state_r == ST_WORDADDR |=> sda_oe_o && bit_r == `EE_ACK_BIT)
      else $error("word address not acknowledged");
   lock_nack_a: assert property (active && fall_e && bit_r == `EE_LAST_BIT
      && state_r == ST_WDATA && locked(upper_half_lock_i, addr_r)
      |=> !sda_oe_o && state_r == ST_IGNORE)
      else $error("protected write acknowledged");
   permit_nack_a: assert property (active && fall_e && bit_r == `EE_LAST_BIT
      && state_r == ST_WDATA && !write_permit_latch_i |=> !sda_oe_o)
      else $error("write acked without permit");
   page_wrap_a: assert property (take_w |=> addr_r[3:0] == $past(addr_r[3:0]) + 4'h1
      && addr_r[8:4] == $past(addr_r[8:4]))
      else $error("page address not wrapped");
   abort_a: assert property (stop_e && !busy_r && bit_r != `EE_BIT_ZERO
      |=> !busy_r)
      else $error("aborted write started cycle");
   seq_inc_a: assert property (rd_load |=> addr_r == $past(addr_r) + 9'h001)
      else $error("read counter not advanced");
   nack_stop_a: assert property (active && fall_e && bit_r == `EE_ACK_BIT
      && state_r == ST_RDATA && !mack_r |=> state_r == ST_IGNORE && !sda_oe_o)
      else $error("read continued after nack");

   cover property (launch_w);
   // saturating gap since the last read load keeps the back-to-back cover short
   logic [7:0] gap_r;
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         gap_r <= '1;
      end else if (rd_load) begin
         gap_r <= '0;
      end else if (gap_r != '1) begin
         gap_r <= gap_r + 8'h01;
      end
   end
   cover property (rd_load && gap_r != '1);
   cover property (done_w);
   cover property (take_w && addr_r[3:0] == 4'hf);
endmodule : ee_slave_core
`default_nettype wire

//--- verification/ee_bus_master.sv
`timescale 1ns/1ns
`default_nettype none
module ee_bus_master (
   input wire logic mclk_i,
   input wire logic sda_oe_i,
   input wire logic sda_val_i,
   output logic scl_o,
   output logic sda_o
);
   logic sda_drv;
   // pull-up wins unless someone pulls low
   assign sda_o = sda_drv & ((sda_oe_i === 1'b1) ? sda_val_i : 1'b1);
   initial begin
      scl_o = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : tick
   // data only moves while the clock is low
   task automatic put_bit(input logic b, output logic r);
      sda_drv = b;
      tick(4);
      scl_o = 1'b1;
      tick(2);
      r = sda_o;
      tick(2);
      scl_o = 1'b0;
   endtask : put_bit
   task automatic start();
      sda_drv = 1'b1;
      tick(2);
      scl_o = 1'b1;
      tick(4);
      sda_drv = 1'b0;
      tick(4);
      scl_o = 1'b0;
   endtask : start
   task automatic stop();
      sda_drv = 1'b0;
      tick(4);
      scl_o = 1'b1;
      tick(4);
      sda_drv = 1'b1;
      tick(4);
   endtask : stop
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i], r);
      end
      put_bit(1'b1, r);
      ack = ~r;
   endtask : send_byte
   task automatic get_byte(input logic more, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, r);
         b[i] = r;
      end
      put_bit(~more, r);
   endtask : get_byte
   // stop inside the ninth clock, once the device has let go of the line
   task automatic read_stop(output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, r);
         b[i] = r;
      end
      stop();
   endtask : read_stop
endmodule : ee_bus_master
`default_nettype wire

//--- verification/tb_ee_slave_core.sv
`timescale 1ns/1ns
`default_nettype none
module tb_ee_slave_core;
   logic mclk;
   logic resetn;
   logic permit;
   logic lock;
   logic sda_val;
   logic scl;
   logic sda;
   logic sda_oe;
   logic busy;
   logic standby;
   int failures = 0;
   int checks = 0;
   int cycles = 0;
   logic [15:0] seed = 16'h8e04;
   logic [8:0] ctr;
   logic [7:0] mem [512];
   logic [7:0] bad [4] = '{8'hb0, 8'ha8, 8'ha4, 8'he0};
   logic k;
   logic [7:0] d;
   always #5 mclk = ~mclk;
   ee_slave_core #(.WR_CYCLES(200)) dut (.mclk_i(mclk), .resetn_i(resetn), .scl_i(scl),
      .sda_i(sda), .write_permit_latch_i(permit), .upper_half_lock_i(lock), .sda_o(sda_val),
      .sda_oe_o(sda_oe), .busy_o(busy), .standby_o(standby));
   ee_bus_master m (.mclk_i(mclk), .sda_oe_i(sda_oe), .sda_val_i(sda_val), .scl_o(scl),
      .sda_o(sda));
   function automatic logic [7:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed[7:0];
   endfunction : rnd
   task automatic complete_run();
      if (failures == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run
   task automatic cmp_bit(input string n, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %b seen %b", n, e, g);
      end
   endtask : cmp_bit
   task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : cmp_byte
   task automatic open_bus(input logic [8:0] a, input logic rd, input logic e);
      m.start();
      m.send_byte({6'h28, a[8], rd}, k);
      cmp_bit("addr_ack", e, k);
   endtask : open_bus
   task automatic set_ptr(input logic [8:0] a, input logic stp);
      open_bus(a, 1'b0, 1'b1);
      m.send_byte(a[7:0], k);
      cmp_bit("word_ack", 1'b1, k);
      ctr = a;
      if (stp) begin
         m.stop();
         m.tick(6);
         cmp_bit("busy", 1'b0, busy);
      end
   endtask : set_ptr
   task automatic do_read(input int n, input logic cut);
      open_bus(9'h000, 1'b1, 1'b1);
      for (int i = 0; i < n; i++) begin
         if (cut && i == n - 1) begin
            m.read_stop(d);
         end else begin
            m.get_byte(i < n - 1, d);
         end
         cmp_byte("rdata", mem[ctr], d);
         ctr = ctr + 9'h001;
      end
      if (!cut) begin
         m.stop();
      end
      m.tick(4);
      cmp_bit("standby", 1'b1, standby);
   endtask : do_read
   task automatic do_write(input logic [8:0] a, input int n, input logic ok);
      logic [3:0] o;
      o = a[3:0];
      set_ptr(a, 1'b0);
      for (int i = 0; i < n; i++) begin
         d = rnd();
         m.send_byte(d, k);
         cmp_bit("data_ack", ok, k);
         if (ok) begin
            mem[{a[8:4], o}] = d;
         end
         o = o + 4'h1;
      end
      m.stop();
      m.tick(6);
      cmp_bit("busy", ok, busy);
      if (ok) begin
         open_bus(a, 1'b0, 1'b0);
         m.stop();
         for (int w = 0; w < 300 && busy === 1'b1; w++) begin
            m.tick(1);
         end
         open_bus(a, 1'b0, 1'b1);
         m.stop();
      end
   endtask : do_write
   // a hang counts against the run
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         complete_run();
      end
   end
   initial begin
      mclk = 1'b0;
      resetn = 1'b0;
      permit = 1'b0;
      lock = 1'b0;
      repeat (10) @(posedge mclk);
      #1;
      resetn = 1'b1;
      m.tick(4);
      cmp_bit("standby", 1'b1, standby);
      foreach (bad[i]) begin
         m.start();
         m.send_byte(bad[i], k);
         cmp_bit("addr_ack", 1'b0, k);
         m.stop();
      end
      permit = 1'b1;
      do_write(9'h1fa, 20, 1'b1);
      d = rnd();
      do_write({5'h00, d[3:0]}, 16, 1'b1);
      set_ptr(9'h1f8, 1'b0);
      do_read(10, 1'b0);
      set_ptr(9'h003, 1'b1);
      do_read(1, 1'b0);
      do_read(2, 1'b1);
      lock = 1'b1;
      do_write(9'h1ff, 1, 1'b0);
      lock = 1'b0;
      permit = 1'b0;
      do_write(9'h002, 1, 1'b0);
      permit = 1'b1;
      set_ptr(9'h001, 1'b0);
      repeat (4) m.put_bit(1'b0, k);
      m.stop();
      m.tick(6);
      cmp_bit("busy", 1'b0, busy);
      set_ptr(9'h1ff, 1'b0);
      do_read(4, 1'b0);
      complete_run();
   end
endmodule : tb_ee_slave_core
`default_nettype wire
